// ==== src/bac_core.sv ====
// Execution control for string stepping, transfers, loops, traps and processor control.
// Assumes an AHB-Lite master that issues single word transfers and a prefetch unit
// that acts on the flush pulse with the fetch address beside it.
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
//
// Contract
// - Indices step up when direction clear, else down.
// - Step one for bytes, two for words.
// - Repeat decrements count by one per element.
// - Repeat with zero count does nothing.
// - Every transfer flushes queue, refetches new address; INT, overflow trap and bound raise int_raise without queue_flush.
// - Near call pushes one, far two.
// - Jumps push nothing onto the stack.
// - Conditional jump adds signed byte displacement.
// - False condition continues with next instruction.
// - Unsigned conditions from carry and zero.
// - Signed conditions from sign, overflow, zero.
// - Single flag tests, positive and negated forms.
// - Loops use count, short signed displacement.
// - Zero-count jump branches when count zero.
// - Overflow trap and bound check raise interrupts.
// - No acknowledge cycle for software or NMI.
// - Other control instructions leave flags unchanged.
// - Flag ops on carry, direction, interrupt enable.
// - Halt stops until interrupt or reset.
// - Wait stalls until test input active.
// - Lock prefix holds bus lock through instruction.
// - Source uses data segment, destination extra.
module bac_core
  import bac_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic intr,
  input wire logic nmi,
  input wire logic test_n,
  output logic queue_flush,
  output logic [15:0] fetch_cs,
  output logic [15:0] fetch_ip,
  output logic [1:0] stack_push,
  output logic [1:0] stack_pop,
  output logic int_raise,
  output logic [7:0] int_vector,
  output logic inta_cycle,
  output logic elem_strobe,
  output logic elem_src_used,
  output logic elem_dst_used,
  output logic src_seg_sel,
  output logic dst_seg_sel,
  output logic [15:0] src_offset,
  output logic [15:0] dst_offset,
  output logic bus_lock,
  output logic halted
);

  typedef struct packed {
    bac_state_t st;
    bac_op_t op;
    bac_cc_t cond;
    logic [7:0] disp;
    logic wsz;
    logic rep;
    logic far;
    logic lock;
    logic [15:0] cx;
    logic [15:0] si;
    logic [15:0] di;
    logic [15:0] ip;
    logic [15:0] cs;
    logic [31:0] tgt;
    logic [31:0] bnd;
    logic cf;
    logic pf;
    logic zf;
    logic sf;
    logic of;
    logic df;
    logic ie;
    logic taken;
    logic wr_pend;
    logic [3:0] wr_idx;
    logic [31:0] rdata;
    logic flush;
    logic [1:0] push;
    logic [1:0] pop;
    logic irq;
    logic [7:0] vec;
    logic inta;
    logic elem;
    logic use_src;
    logic use_dst;
    logic [15:0] eso;
    logic [15:0] edo;
  } bac_regs_t;

  bac_regs_t s;
  bac_regs_t n;

  function automatic logic cond_true(input bac_cc_t cc, input bac_regs_t r);
    logic t;
    t = 1'b0;
    unique case (cc)
      CC_O: t = r.of;
      CC_NO: t = !r.of;
      CC_B: t = r.cf;
      CC_AE: t = !r.cf;
      CC_E: t = r.zf;
      CC_NE: t = !r.zf;
      CC_BE: t = r.cf | r.zf;
      CC_A: t = !(r.cf | r.zf);
      CC_S: t = r.sf;
      CC_NS: t = !r.sf;
      CC_P: t = r.pf;
      CC_NP: t = !r.pf;
      CC_L: t = r.sf ^ r.of;
      CC_GE: t = !(r.sf ^ r.of);
      CC_LE: t = (r.sf ^ r.of) | r.zf;
      CC_G: t = !((r.sf ^ r.of) | r.zf);
    endcase
    return t;
  endfunction : cond_true

  function automatic logic [31:0] read_reg(input logic [3:0] idx, input bac_regs_t r);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (idx)
      REG_FLAGS:
      begin
        d[FLG_CF] = r.cf;
        d[FLG_PF] = r.pf;
        d[FLG_ZF] = r.zf;
        d[FLG_SF] = r.sf;
        d[FLG_IE] = r.ie;
        d[FLG_DF] = r.df;
        d[FLG_OF] = r.of;
      end
      REG_COUNT: d[15:0] = r.cx;
      REG_SRC: d[15:0] = r.si;
      REG_DST: d[15:0] = r.di;
      REG_IP: d[15:0] = r.ip;
      REG_CS: d[15:0] = r.cs;
      REG_TARGET: d = r.tgt;
      REG_BOUND: d = r.bnd;
      REG_STATUS:
      begin
        d[STS_BUSY] = r.st != ST_IDLE;
        d[STS_HALT] = r.st == ST_HALT;
        d[STS_WAIT] = r.st == ST_WAIT;
        d[STS_TAKEN] = r.taken;
      end
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_reg

  logic acc;
  logic [15:0] stp;
  logic [15:0] dsp;
  logic [15:0] cx_dec;
  logic is_str;
  logic str_src;
  logic str_dst;

  assign acc = hsel & htrans[1] & hready;
  assign stp = s.wsz ? STEP_WORD : STEP_BYTE;
  assign dsp = {{8{s.disp[7]}}, s.disp};
  assign cx_dec = s.cx - 16'h0001;
  assign is_str = s.op inside {OP_MOVS, OP_CMPS, OP_SCAS, OP_LODS, OP_STOS, OP_INS, OP_OUTS};
  assign str_src = s.op inside {OP_MOVS, OP_CMPS, OP_LODS, OP_OUTS};
  assign str_dst = s.op inside {OP_MOVS, OP_CMPS, OP_SCAS, OP_STOS, OP_INS};

  always_comb
  begin
    n = s;
    n.flush = 1'b0;
    n.push = 2'h0;
    n.pop = 2'h0;
    n.irq = 1'b0;
    n.inta = 1'b0;
    n.elem = 1'b0;
    // Software may only change architectural state while no command is running,
    // so hardware updates never collide with bus writes.
    if (s.wr_pend && s.st == ST_IDLE)
    begin
      unique case (s.wr_idx)
        REG_CMD:
        begin
          n.op = bac_op_t'(hwdata[CMD_OP_LSB +: 5]);
          n.cond = bac_cc_t'(hwdata[CMD_COND_LSB +: 4]);
          n.disp = hwdata[CMD_DISP_LSB +: 8];
          n.wsz = hwdata[CMD_WORD];
          n.rep = hwdata[CMD_REP];
          n.far = hwdata[CMD_FAR];
          n.lock = hwdata[CMD_LOCK];
          n.taken = 1'b0;
          n.st = ST_EXEC;
        end
        REG_FLAGS:
        begin
          n.cf = hwdata[FLG_CF];
          n.pf = hwdata[FLG_PF];
          n.zf = hwdata[FLG_ZF];
          n.sf = hwdata[FLG_SF];
          n.ie = hwdata[FLG_IE];
          n.df = hwdata[FLG_DF];
          n.of = hwdata[FLG_OF];
        end
        REG_COUNT: n.cx = hwdata[15:0];
        REG_SRC: n.si = hwdata[15:0];
        REG_DST: n.di = hwdata[15:0];
        REG_IP: n.ip = hwdata[15:0];
        REG_CS: n.cs = hwdata[15:0];
        REG_TARGET: n.tgt = hwdata;
        REG_BOUND: n.bnd = hwdata;
        default: n.st = s.st;
      endcase
    end
    unique case (s.st)
      ST_IDLE: n.st = n.st;
      ST_EXEC:
      begin
        n.st = ST_IDLE;
        n.lock = 1'b0;
        if (is_str)
        begin
          if (!(s.rep && s.cx == 16'h0000))
          begin
            n.elem = 1'b1;
            n.use_src = str_src;
            n.use_dst = str_dst;
            n.eso = s.si;
            n.edo = s.di;
            if (str_src)
              n.si = s.df ? s.si - stp : s.si + stp;
            if (str_dst)
              n.di = s.df ? s.di - stp : s.di + stp;
            if (s.rep)
            begin
              n.cx = cx_dec;
              if (cx_dec != 16'h0000)
              begin
                n.st = ST_EXEC;
                n.lock = s.lock;
              end
            end
          end
        end
        else
        begin
          unique case (s.op)
            OP_JCC:
              if (cond_true(s.cond, s))
              begin
                n.ip = s.ip + dsp;
                n.taken = 1'b1;
                n.flush = 1'b1;
              end
            OP_LOOP, OP_LOOPE, OP_LOOPNE:
            begin
              n.cx = cx_dec;
              if (cx_dec != 16'h0000 && (s.op == OP_LOOP || (s.op == OP_LOOPE) == s.zf))
              begin
                n.ip = s.ip + dsp;
                n.taken = 1'b1;
                n.flush = 1'b1;
              end
            end
            OP_JUMP_ON_ZERO_COUNT:
              if (s.cx == 16'h0000)
              begin
                n.ip = s.ip + dsp;
                n.taken = 1'b1;
                n.flush = 1'b1;
              end
            OP_JMP, OP_CALL, OP_RET:
            begin
              n.ip = s.tgt[15:0];
              if (s.far)
                n.cs = s.tgt[31:16];
              n.taken = 1'b1;
              n.flush = 1'b1;
              if (s.op == OP_CALL)
                n.push = s.far ? PUSH_FAR : PUSH_NEAR;
              if (s.op == OP_RET)
                n.pop = s.far ? PUSH_FAR : PUSH_NEAR;
            end
            OP_INT, OP_OVERFLOW_TRAP_INSTRUCTION, OP_BOUND:
            begin
              // Software interrupts never pulse the acknowledge output.
              n.vec = s.op == OP_INT ? s.disp : (s.op == OP_OVERFLOW_TRAP_INSTRUCTION ? VEC_OVF : VEC_BOUND);
              if (s.op == OP_INT || (s.op == OP_OVERFLOW_TRAP_INSTRUCTION && s.of) ||
                  (s.op == OP_BOUND && ($signed(s.tgt[15:0]) < $signed(s.bnd[15:0]) ||
                  $signed(s.tgt[15:0]) > $signed(s.bnd[31:16]))))
              begin
                n.irq = 1'b1;
                n.push = PUSH_INT;
              end
            end
            OP_IRET:
            begin
              n.ip = s.tgt[15:0];
              n.cs = s.tgt[31:16];
              n.pop = PUSH_INT;
              n.taken = 1'b1;
              n.flush = 1'b1;
            end
            OP_STC: n.cf = 1'b1;
            OP_CLC: n.cf = 1'b0;
            OP_CMC: n.cf = !s.cf;
            OP_STD: n.df = 1'b1;
            OP_CLD: n.df = 1'b0;
            OP_STI: n.ie = 1'b1;
            OP_CLI: n.ie = 1'b0;
            OP_HLT: n.st = ST_HALT;
            OP_WAIT: n.st = ST_WAIT;
            default: n.st = ST_IDLE;
          endcase
        end
      end
      ST_HALT:
        if (nmi)
        begin
          n.irq = 1'b1;
          n.vec = VEC_NMI;
          n.st = ST_IDLE;
        end
        else if (intr && s.ie)
        begin
          n.irq = 1'b1;
          n.inta = 1'b1;
          n.vec = VEC_EXT;
          n.st = ST_IDLE;
        end
      ST_WAIT:
        if (!test_n)
          n.st = ST_IDLE;
    endcase
    n.wr_pend = acc & hwrite;
    n.wr_idx = haddr[IDX_MSB:IDX_LSB];
    // Reads see this cycle's pending write, so a read right after a write is current.
    if (acc && !hwrite)
      n.rdata = read_reg(haddr[IDX_MSB:IDX_LSB], n);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= n;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign queue_flush = s.flush;
  assign fetch_cs = s.cs;
  assign fetch_ip = s.ip;
  assign stack_push = s.push;
  assign stack_pop = s.pop;
  assign int_raise = s.irq;
  assign int_vector = s.vec;
  assign inta_cycle = s.inta;
  assign elem_strobe = s.elem;
  assign elem_src_used = s.use_src;
  assign elem_dst_used = s.use_dst;
  assign src_seg_sel = SEG_DATA;
  assign dst_seg_sel = SEG_EXTRA;
  assign src_offset = s.eso;
  assign dst_offset = s.edo;
  assign bus_lock = s.lock;
  assign halted = s.st == ST_HALT;

endmodule : bac_core

// ==== src/bac_pkg.sv ====
// Constants, register map and command encodings for the branch and string control unit.
// Assumes a single AHB-Lite master and a core that feeds commands one at a time.
package bac_pkg;
  // Register word indices; the byte address is four times the index.
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_FLAGS = 4'h1;
  localparam logic [3:0] REG_COUNT = 4'h2;
  localparam logic [3:0] REG_SRC = 4'h3;
  localparam logic [3:0] REG_DST = 4'h4;
  localparam logic [3:0] REG_IP = 4'h5;
  localparam logic [3:0] REG_CS = 4'h6;
  localparam logic [3:0] REG_TARGET = 4'h7;
  localparam logic [3:0] REG_BOUND = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 5;
  // Command word fields.
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_COND_LSB = 5;
  localparam int CMD_WORD = 9;
  localparam int CMD_REP = 10;
  localparam int CMD_LOCK = 11;
  localparam int CMD_FAR = 12;
  localparam int CMD_DISP_LSB = 16;
  // Flag bit positions in the flags register.
  localparam int FLG_CF = 0;
  localparam int FLG_PF = 2;
  localparam int FLG_ZF = 6;
  localparam int FLG_SF = 7;
  localparam int FLG_IE = 9;
  localparam int FLG_DF = 10;
  localparam int FLG_OF = 11;
  // Status register bits.
  localparam int STS_BUSY = 0;
  localparam int STS_HALT = 1;
  localparam int STS_WAIT = 2;
  localparam int STS_TAKEN = 3;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [1:0] PUSH_NEAR = 2'h1;
  localparam logic [1:0] PUSH_FAR = 2'h2;
  localparam logic [1:0] PUSH_INT = 2'h3;
  localparam logic [7:0] VEC_NMI = 8'h02;
  localparam logic [7:0] VEC_OVF = 8'h04;
  localparam logic [7:0] VEC_BOUND = 8'h05;
  localparam logic [7:0] VEC_EXT = 8'h20;
  localparam logic SEG_DATA = 1'b0;
  localparam logic SEG_EXTRA = 1'b1;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_MOVS = 5'h01, OP_CMPS = 5'h02, OP_SCAS = 5'h03,
    OP_LODS = 5'h04, OP_STOS = 5'h05, OP_INS = 5'h06, OP_OUTS = 5'h07,
    OP_JCC = 5'h08, OP_JMP = 5'h09, OP_CALL = 5'h0A, OP_RET = 5'h0B,
    OP_LOOP = 5'h0C, OP_LOOPE = 5'h0D, OP_LOOPNE = 5'h0E, OP_JUMP_ON_ZERO_COUNT = 5'h0F,
    OP_INT = 5'h10, OP_OVERFLOW_TRAP_INSTRUCTION = 5'h11, OP_BOUND = 5'h12, OP_IRET = 5'h13,
    OP_STC = 5'h14, OP_CLC = 5'h15, OP_CMC = 5'h16, OP_STD = 5'h17,
    OP_CLD = 5'h18, OP_STI = 5'h19, OP_CLI = 5'h1A, OP_HLT = 5'h1B,
    OP_WAIT = 5'h1C
  } bac_op_t;
  typedef enum logic [3:0] {
    CC_O = 4'h0, CC_NO = 4'h1, CC_B = 4'h2, CC_AE = 4'h3,
    CC_E = 4'h4, CC_NE = 4'h5, CC_BE = 4'h6, CC_A = 4'h7,
    CC_S = 4'h8, CC_NS = 4'h9, CC_P = 4'hA, CC_NP = 4'hB,
    CC_L = 4'hC, CC_GE = 4'hD, CC_LE = 4'hE, CC_G = 4'hF
  } bac_cc_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_HALT = 2'b10, ST_WAIT = 2'b11
  } bac_state_t;
endpackage : bac_pkg

// ==== verif/bac_core_properties.sv ====
// Concurrent checks on the outputs of the branch and string control unit.
// Assumes it is bound to bac_core and sees only that module's ports.
`timescale 1ns/1ps
module bac_core_checker
  import bac_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic intr,
  input wire logic nmi,
  input wire logic queue_flush,
  input wire logic [15:0] fetch_ip,
  input wire logic [1:0] stack_push,
  input wire logic [1:0] stack_pop,
  input wire logic int_raise,
  input wire logic inta_cycle,
  input wire logic src_seg_sel,
  input wire logic dst_seg_sel,
  input wire logic halted
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_call_push;
    stack_push == PUSH_NEAR || stack_push == PUSH_FAR;
  endsequence
  sequence s_nmi_wake;
    halted && nmi;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_seg_default: assert property (src_seg_sel == SEG_DATA && dst_seg_sel == SEG_EXTRA)
    else $error("string segment selection wrong");
  a_call_flush: assert property (s_call_push |-> queue_flush)
    else $error("call pushed without queue flush");
  a_pop_flush: assert property (stack_pop != 2'h0 |-> queue_flush)
    else $error("return popped without queue flush");
  a_flush_once: assert property (queue_flush |=> !queue_flush && $stable(fetch_ip))
    else $error("flush longer than one cycle or fetch address moved");
  a_push_pulse: assert property (stack_push != 2'h0 |=> stack_push == 2'h0)
    else $error("stack push held for more than one cycle");
  a_ack_hw_only: assert property (inta_cycle |-> int_raise && $past(halted))
    else $error("acknowledge cycle outside a halt wake");
  a_nmi_no_ack: assert property (s_nmi_wake |-> ##[1:3] (int_raise && !inta_cycle))
    else $error("nonmaskable wake missing or acknowledged");
  a_halt_stays: assert property (halted && !nmi && !intr |=> halted)
    else $error("halt left without a request");
endmodule : bac_core_checker

bind bac_core bac_core_checker bac_core_checker_i (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .intr(intr), .nmi(nmi), .queue_flush(queue_flush),
  .fetch_ip(fetch_ip), .stack_push(stack_push), .stack_pop(stack_pop), .int_raise(int_raise),
  .inta_cycle(inta_cycle), .src_seg_sel(src_seg_sel), .dst_seg_sel(dst_seg_sel),
  .halted(halted));

// ==== verif/bac_biu_model.sv ====
// Behavioural bus interface unit: prefetch refill, stack traffic and the test pin.
// Assumes single-cycle pulses from the execution control on the shared clock.
`timescale 1ns/1ps
module bac_biu_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic queue_flush,
  input wire logic [15:0] fetch_ip,
  input wire logic [1:0] stack_push,
  input wire logic [1:0] stack_pop,
  input wire logic int_raise,
  input wire logic inta_cycle,
  input wire logic elem_strobe,
  input wire logic bus_lock,
  input wire logic resume,
  output logic test_n
);
  int depth = 0;
  int flushes = 0;
  int ints = 0;
  int acks = 0;
  int elems = 0;
  int locks = 0;
  logic [15:0] last_ip = 16'h0000;
  always @(posedge hclk)
  begin
    if (hresetn && queue_flush)
    begin
      // Stale queue contents are dropped; refill starts at the new address.
      flushes <= flushes + 1;
      last_ip <= fetch_ip;
    end
    if (hresetn)
    begin
      depth <= depth + int'(stack_push) - int'(stack_pop);
      ints <= ints + int'(int_raise);
      acks <= acks + int'(inta_cycle);
      elems <= elems + int'(elem_strobe);
      locks <= locks + int'(bus_lock);
    end
    // Released one cycle late, so the unit must really wait on the pin.
    test_n <= !resume;
  end
endmodule : bac_biu_model

// ==== verif/tb_bac_core.sv ====
// Self-checking bench for bac_core, driven over its register bus.
// Assumes zero-wait-state answers and the bus interface model beside the unit.
`timescale 1ns/1ps
module tb_bac_core;
  import bac_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic intr = 1'b0, nmi = 1'b0, resume = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, queue_flush, int_raise, inta_cycle, elem_strobe, bus_lock, halted;
  logic elem_src_used, elem_dst_used, src_seg_sel, dst_seg_sel, test_n;
  logic [15:0] fetch_cs, fetch_ip, src_offset, dst_offset;
  logic [1:0] stack_push, stack_pop;
  logic [7:0] int_vector;
  logic [31:0] pat [4] = '{32'h0, 32'h08C5, 32'h0080, 32'h0801};
  int num_errors = 0;
  int checks_done = 0;
  always #12.5 hclk = ~hclk;
  bac_core bac_core_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .intr, .nmi, .test_n,
    .queue_flush, .fetch_cs, .fetch_ip, .stack_push, .stack_pop, .int_raise, .int_vector,
    .inta_cycle, .elem_strobe, .elem_src_used, .elem_dst_used, .src_seg_sel, .dst_seg_sel,
    .src_offset, .dst_offset, .bus_lock, .halted);
  bac_biu_model bac_biu_model_i (.hclk, .hresetn, .queue_flush, .fetch_ip, .stack_push,
    .stack_pop, .int_raise, .inta_cycle, .elem_strobe, .bus_lock, .resume, .test_n);
  task automatic end_of_test();
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdy();
    int n = 0;
    do
      @(posedge hclk);
    while (hreadyout !== 1'b1 && ++n < 20);
    if (n >= 20)
      chk(32'h0, 32'h1);
    if (n >= 20)
      end_of_test();
  endtask : rdy
  task automatic bus(logic [3:0] idx, logic w, logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {26'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(logic [3:0] idx, logic [31:0] d);
    logic [31:0] x;
    bus(idx, 1'b1, d, x);
  endtask : wr
  task automatic rd(logic [3:0] idx, output logic [31:0] v);
    bus(idx, 1'b0, 32'h0, v);
  endtask : rd
  task automatic poll(int b, logic v);
    logic [31:0] s;
    int n = 0;
    do
      rd(REG_STATUS, s);
    while (s[b] !== v && ++n < 100);
    if (n >= 100)
      chk(32'h0, 32'h1);
    if (n >= 100)
      end_of_test();
  endtask : poll
  function automatic logic [31:0] mk(bac_op_t op, logic [3:0] cc, logic [3:0] fl, logic [7:0] d);
    return {8'h00, d, 3'h0, fl, cc, op};
  endfunction : mk
  task automatic run(logic [31:0] c);
    wr(REG_CMD, c);
    poll(STS_BUSY, 1'b0);
    // Output pulses reach the model's counters no later than the edge the poll ends on.
    @(posedge hclk);
  endtask : run
  function automatic logic cond_ok(logic [3:0] c, logic [31:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[FLG_OF];
      3'h1: r = f[FLG_CF];
      3'h2: r = f[FLG_ZF];
      3'h3: r = f[FLG_CF] | f[FLG_ZF];
      3'h4: r = f[FLG_SF];
      3'h5: r = f[FLG_PF];
      3'h6: r = f[FLG_SF] ^ f[FLG_OF];
      default: r = (f[FLG_SF] ^ f[FLG_OF]) | f[FLG_ZF];
    endcase
    return r ^ c[0];
  endfunction : cond_ok
  task automatic t_str(bac_op_t op, logic w, logic df, logic [15:0] n);
    logic [31:0] v;
    logic [15:0] st, es, ed, s1;
    logic us, ud;
    int e0;
    s1 = w ? 16'h2 : 16'h1;
    s1 = df ? -s1 : s1;
    us = op inside {OP_MOVS, OP_CMPS, OP_LODS, OP_OUTS};
    ud = op inside {OP_MOVS, OP_CMPS, OP_SCAS, OP_STOS, OP_INS};
    st = w ? 16'h2 * n : n;
    st = df ? -st : st;
    es = us ? st : 16'h0;
    ed = ud ? st : 16'h0;
    e0 = bac_biu_model_i.elems;
    wr(REG_FLAGS, {21'h0, df, 10'h0});
    wr(REG_COUNT, {16'h0, n});
    wr(REG_SRC, 32'h0100);
    wr(REG_DST, 32'h0200);
    run(mk(op, 4'h0, {2'b00, 1'b1, w}, 8'h00));
    rd(REG_SRC, v);
    chk(v, {16'h0, 16'h0100 + es});
    rd(REG_DST, v);
    chk(v, {16'h0, 16'h0200 + ed});
    rd(REG_COUNT, v);
    chk(v, 32'h0);
    chk(bac_biu_model_i.elems - e0, n);
    if (n != 16'h0)
    begin
      chk({elem_src_used, elem_dst_used}, {us, ud});
      v = {16'h0100 + es - (us ? s1 : 16'h0), 16'h0200 + ed - (ud ? s1 : 16'h0)};
      chk({src_offset, dst_offset}, v);
    end
  endtask : t_str
  task automatic t_br(bac_op_t op, logic [3:0] cc, logic [31:0] f, logic [15:0] cnt,
                      logic [7:0] d, logic [15:0] ecnt, logic tk);
    logic [31:0] v;
    logic [15:0] ip;
    int f0;
    logic [15:0] l0;
    ip = tk ? 16'h1000 + {{8{d[7]}}, d} : 16'h1000;
    f0 = bac_biu_model_i.flushes;
    l0 = bac_biu_model_i.last_ip;
    wr(REG_FLAGS, f);
    wr(REG_COUNT, {16'h0, cnt});
    wr(REG_IP, 32'h1000);
    run(mk(op, cc, 4'h0, d));
    rd(REG_IP, v);
    chk(v, {16'h0, ip});
    rd(REG_COUNT, v);
    chk(v, {16'h0, ecnt});
    chk(bac_biu_model_i.flushes - f0, tk);
    chk(bac_biu_model_i.last_ip, tk ? ip : l0);
  endtask : t_br
  task automatic t_op(bac_op_t op, logic [3:0] fl, logic [31:0] f, logic [31:0] tg,
                      logic [7:0] d, int dd, int di);
    int d0;
    int i0;
    int a0;
    logic [15:0] c0;
    c0 = fetch_cs;
    d0 = bac_biu_model_i.depth;
    i0 = bac_biu_model_i.ints;
    a0 = bac_biu_model_i.acks;
    wr(REG_FLAGS, f);
    wr(REG_TARGET, tg);
    wr(REG_BOUND, 32'h0010_FFF0);
    run(mk(op, 4'h0, fl, d));
    chk(bac_biu_model_i.depth - d0, dd);
    chk(bac_biu_model_i.ints - i0, di);
    chk(bac_biu_model_i.acks - a0, 0);
    if (op inside {OP_JMP, OP_CALL, OP_RET, OP_IRET})
      chk({fetch_cs, fetch_ip}, fl[3] || op == OP_IRET ? tg : {c0, tg[15:0]});
    if (di != 0)
      chk(int_vector, op == OP_INT ? d : (op == OP_OVERFLOW_TRAP_INSTRUCTION ? VEC_OVF : VEC_BOUND));
  endtask : t_op
  task automatic t_fl();
    logic [31:0] v;
    logic [31:0] b;
    logic [31:0] e;
    bac_op_t op;
    wr(4'hF, 32'hFFFF_FFFF);
    rd(4'hF, v);
    chk(v, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      op = k == 7 ? OP_NOP : bac_op_t'(OP_STC + k);
      b = k[0] ? 32'h08C5 : 32'h0EC4;
      wr(REG_FLAGS, b);
      run(mk(op, 4'h0, 4'h0, 8'h00));
      case (op)
        OP_STC: e = b | 32'h1;
        OP_CLC: e = b & ~32'h1;
        OP_CMC: e = b ^ 32'h1;
        OP_STD: e = b | 32'h400;
        OP_CLD: e = b & ~32'h400;
        OP_STI: e = b | 32'h200;
        OP_CLI: e = b & ~32'h200;
        default: e = b;
      endcase
      rd(REG_FLAGS, v);
      chk(v, e);
    end
  endtask : t_fl
  task automatic t_ext();
    logic [31:0] v;
    int a0;
    a0 = bac_biu_model_i.acks;
    wr(REG_FLAGS, 32'h08C5);
    wr(REG_CMD, mk(OP_HLT, 4'h0, 4'h0, 8'h00));
    poll(STS_HALT, 1'b1);
    intr <= 1'b1;
    rd(REG_STATUS, v);
    rd(REG_STATUS, v);
    chk(v[STS_HALT], 1'b1);
    intr <= 1'b0;
    nmi <= 1'b1;
    poll(STS_HALT, 1'b0);
    nmi <= 1'b0;
    chk(int_vector, VEC_NMI);
    rd(REG_FLAGS, v);
    chk(v, 32'h08C5);
    wr(REG_FLAGS, 32'h0200);
    wr(REG_CMD, mk(OP_HLT, 4'h0, 4'h0, 8'h00));
    poll(STS_HALT, 1'b1);
    intr <= 1'b1;
    poll(STS_HALT, 1'b0);
    intr <= 1'b0;
    @(posedge hclk);
    chk(bac_biu_model_i.acks - a0, 1);
    chk(int_vector, VEC_EXT);
    wr(REG_CMD, mk(OP_WAIT, 4'h0, 4'h0, 8'h00));
    poll(STS_WAIT, 1'b1);
    rd(REG_STATUS, v);
    chk(v[STS_WAIT], 1'b1);
    resume <= 1'b1;
    poll(STS_BUSY, 1'b0);
    resume <= 1'b0;
    a0 = bac_biu_model_i.locks;
    run(mk(OP_NOP, 4'h0, 4'h4, 8'h00));
    chk(bac_biu_model_i.locks > a0, 1'b1);
  endtask : t_ext
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_str(OP_MOVS, 1'b1, 1'b0, 16'h3);
    t_str(OP_LODS, 1'b0, 1'b1, 16'h2);
    t_str(OP_STOS, 1'b1, 1'b1, 16'h0);
    t_str(OP_SCAS, 1'b0, 1'b0, 16'h1);
    t_str(OP_CMPS, 1'b1, 1'b1, 16'h2);
    t_str(OP_OUTS, 1'b0, 1'b0, 16'h2);
    t_str(OP_INS, 1'b1, 1'b0, 16'h1);
    for (int p = 0; p < 4; p++)
      for (int c = 0; c < 16; c++)
        t_br(OP_JCC, c[3:0], pat[p], 16'h0, p[0] ? 8'h7F : 8'h80, 16'h0,
             cond_ok(c[3:0], pat[p]));
    t_br(OP_LOOP, 4'h0, 32'h0, 16'h2, 8'h10, 16'h1, 1'b1);
    t_br(OP_LOOP, 4'h0, 32'h0, 16'h1, 8'h10, 16'h0, 1'b0);
    t_br(OP_LOOPE, 4'h0, 32'h0, 16'h2, 8'h10, 16'h1, 1'b0);
    t_br(OP_LOOPE, 4'h0, 32'h40, 16'h2, 8'h80, 16'h1, 1'b1);
    t_br(OP_LOOPNE, 4'h0, 32'h0, 16'h2, 8'h7F, 16'h1, 1'b1);
    t_br(OP_JUMP_ON_ZERO_COUNT, 4'h0, 32'h0, 16'h0, 8'h10, 16'h0, 1'b1);
    t_br(OP_JUMP_ON_ZERO_COUNT, 4'h0, 32'h0, 16'h5, 8'h10, 16'h5, 1'b0);
    t_op(OP_CALL, 4'h0, 32'h0, 32'h2000_0300, 8'h00, 1, 0);
    t_op(OP_CALL, 4'h8, 32'h0, 32'h2000_0300, 8'h00, 2, 0);
    t_op(OP_RET, 4'h8, 32'h0, 32'h2000_0300, 8'h00, -2, 0);
    t_op(OP_RET, 4'h0, 32'h0, 32'h2000_0300, 8'h00, -1, 0);
    t_op(OP_JMP, 4'h8, 32'h0, 32'h2000_0300, 8'h00, 0, 0);
    t_op(OP_JMP, 4'h0, 32'h0, 32'h2000_0300, 8'h00, 0, 0);
    t_op(OP_OVERFLOW_TRAP_INSTRUCTION, 4'h0, 32'h0, 32'h0, 8'h00, 0, 0);
    t_op(OP_OVERFLOW_TRAP_INSTRUCTION, 4'h0, 32'h0800, 32'h0, 8'h00, 3, 1);
    t_op(OP_BOUND, 4'h0, 32'h0, 32'h0010, 8'h00, 0, 0);
    t_op(OP_BOUND, 4'h0, 32'h0, 32'h0011, 8'h00, 3, 1);
    t_op(OP_BOUND, 4'h0, 32'h0, 32'hFFEF, 8'h00, 3, 1);
    t_op(OP_INT, 4'h0, 32'h0, 32'h0, 8'h21, 3, 1);
    t_op(OP_IRET, 4'h0, 32'h0, 32'h3000_0400, 8'h00, -3, 0);
    t_fl();
    t_ext();
    end_of_test();
  end
endmodule : tb_bac_core
